// ===== rtl/ctbs_regs.svh
// Purpose: Constants of the transfer, bit and shift execution group
// Assumes: Included by the design files by bare name
// Notes: Definitions only
`ifndef CTBS_REGS_SVH
`define CTBS_REGS_SVH

// ----------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------
`define CTBS_STATUS_FLAGS_REGISTER_C 3'd0
`define CTBS_STATUS_FLAGS_REGISTER_Z 3'd1
`define CTBS_STATUS_FLAGS_REGISTER_N 3'd2
`define CTBS_STATUS_FLAGS_REGISTER_V 3'd3
`define CTBS_STATUS_FLAGS_REGISTER_S 3'd4
`define CTBS_STATUS_FLAGS_REGISTER_H 3'd5
`define CTBS_STATUS_FLAGS_REGISTER_T 3'd6
`define CTBS_STATUS_FLAGS_REGISTER_I 3'd7

// ----------------------------------------------------------------
// Reset values and fixed operands
// ----------------------------------------------------------------
`define CTBS_STATUS_FLAGS_REGISTER_RESET 8'h00
`define CTBS_R0_INDEX 5'h00
`define CTBS_Z_STEP 16'h0001

`endif

// ===== rtl/ctbs_pkg.sv
// Purpose: Types of the transfer, bit and shift execution group
// Assumes: Fixed 8-bit data, 16-bit program pointer, 6-bit I/O address
// Notes: Constants live in ctbs_regs.svh
package ctbs_pkg;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_PROGRAM_MEMORY_READ_R0 = 5'h01,
		OP_PROGRAM_MEMORY_READ = 5'h02,
		OP_PROGRAM_MEMORY_READ_INC = 5'h03,
		OP_PROGRAM_MEMORY_WRITE = 5'h04,
		OP_IO_IN = 5'h05,
		OP_IO_OUT = 5'h06,
		OP_PUSH = 5'h07,
		OP_POP = 5'h08,
		OP_IO_BIT_SET = 5'h09,
		OP_IO_BIT_CLEAR = 5'h0a,
		OP_LOGICAL_LEFT_SHIFT = 5'h0b,
		OP_LOGICAL_RIGHT_SHIFT = 5'h0c,
		OP_ROTATE_LEFT_CARRY = 5'h0d,
		OP_ROTATE_RIGHT_CARRY = 5'h0e,
		OP_ARITHMETIC_RIGHT_SHIFT = 5'h0f,
		OP_NIBBLE_SWAP = 5'h10,
		OP_FLAG_SET_GENERIC = 5'h11,
		OP_FLAG_CLEAR_GENERIC = 5'h12,
		OP_BIT_TO_TRANSFER_FLAG = 5'h13,
		OP_BIT_FROM_TRANSFER_FLAG = 5'h14,
		OP_CARRY_FORCE_ONE = 5'h15,
		OP_CARRY_FORCE_ZERO = 5'h16
	} ctbs_op_t;

	// Gray along idle -> step1 -> step2
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STEP1 = 2'b01,
		ST_STEP2 = 2'b11
	} ctbs_state_t;

	typedef struct packed {
		ctbs_op_t op;
		logic [4:0] dst;
		logic [7:0] dst_val;
		logic [7:0] src_val;
		logic [5:0] io_addr;
		logic [2:0] bit_sel;
		logic [15:0] z;
		logic [15:0] word;
	} ctbs_cmd_t;

	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [7:0] data;
	} ctbs_rf_wr_t;

	typedef struct packed {
		logic en;
		logic [15:0] data;
	} ctbs_z_wr_t;

	typedef struct packed {
		logic rd_en;
		logic wr_en;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ctbs_pm_t;

	typedef struct packed {
		logic en;
		logic [5:0] addr;
		logic [7:0] data;
	} ctbs_io_wr_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic [7:0] wdata;
	} ctbs_stk_t;

	typedef struct packed {
		logic [7:0] result;
		logic c;
		logic z;
		logic n;
		logic v;
	} ctbs_shift_t;

endpackage

// ===== rtl/ctbs_shifter.sv
// Purpose: Combinational shift and rotate unit with flag results
// Assumes: Caller applies the result only for shift opcodes
// Notes: Overflow is negative xor carry of the result
`timescale 1ns/1ns
`include "ctbs_regs.svh"

module ctbs_shifter (
	input wire ctbs_pkg::ctbs_op_t op,
	input wire logic [7:0] value,
	input wire logic carry_in,
	output ctbs_pkg::ctbs_shift_t res
);
	import ctbs_pkg::*;

	always_comb begin
		res.result = value;
		res.c = carry_in;
		case (op)
			OP_LOGICAL_LEFT_SHIFT: begin
				res.result = {value[6:0], 1'b0};
				res.c = value[7];
			end
			OP_LOGICAL_RIGHT_SHIFT: begin
				res.result = {1'b0, value[7:1]};
				res.c = value[0];
			end
			OP_ROTATE_LEFT_CARRY: begin
				res.result = {value[6:0], carry_in};
				res.c = value[7];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res.result = {carry_in, value[7:1]};
				res.c = value[0];
			end
			OP_ARITHMETIC_RIGHT_SHIFT: begin
				res.result = {value[7], value[7:1]};
				res.c = value[0];
			end
			default: begin
				res.result = value;
				res.c = carry_in;
			end
		endcase
		res.n = res.result[7];
		res.z = (res.result == 8'h00);
		res.v = res.result[7] ^ res.c;
	end

endmodule

// ===== rtl/ctbs_core.sv
// Purpose: Executes transfer, I/O bit, shift and flag instructions of an 8-bit core
// Assumes: Register file operands arrive with the command; io_rd_data is the
//          I/O register at cmd.io_addr in the same cycle; the stack top byte is
//          read during the pop strobe; program memory returns read data in the
//          cycle after its read strobe
// Notes: Owns the status flags; the rest of the core may load them when idle and no command is accepted
`timescale 1ns/1ns
`include "ctbs_regs.svh"

// Behaviour
// - Implied read loads program byte into R0
// - Post-increment read loads byte, bumps Z
// - Program store writes R1:R0 at Z
// - Input copies I/O register in one cycle
// - Output writes I/O register in one cycle
// - Push stores source over two cycles
// - Pop loads destination over two cycles
// - I/O bit set/clear, two cycles
// - Left shift, zero fill, four flags
// - Right shift, zero fill, carry gets bit0
// - Rotate left through carry, four flags
// - Rotate right through carry, four flags
// - Nibble swap, no flag change
// - Generic flag set/clear, one bit only
// - Selected source bit copied into T
// - Carry forced to one or zero
module ctbs_core (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire ctbs_pkg::ctbs_cmd_t cmd,
	output logic cmd_ready,
	input wire logic [7:0] io_rd_data,
	input wire logic [15:0] pm_rd_data,
	input wire logic [7:0] stack_rd_data,
	input wire logic status_flags_register_load_en,
	input wire logic [7:0] status_flags_register_load_val,
	output ctbs_pkg::ctbs_rf_wr_t rf_wr,
	output ctbs_pkg::ctbs_z_wr_t z_wr,
	output ctbs_pkg::ctbs_pm_t pm,
	output ctbs_pkg::ctbs_io_wr_t io_wr,
	output ctbs_pkg::ctbs_stk_t stk,
	output logic [7:0] status_flags_register,
	output logic done
);
	import ctbs_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ctbs_state_t state;
		ctbs_op_t pend_op;
		logic [4:0] pend_dst;
		logic pend_odd;
		logic ready;
		logic done;
		ctbs_rf_wr_t rf_wr;
		ctbs_z_wr_t z_wr;
		ctbs_pm_t pm;
		ctbs_io_wr_t io_wr;
		ctbs_stk_t stk;
		logic [7:0] status_flags_register;
	} ctbs_core_st_t;

	ctbs_core_st_t st_q;
	ctbs_core_st_t st_d;
	ctbs_shift_t shift_res;
	logic accept;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Program memory is word wide; Z bit 0 picks the byte
	function automatic logic [7:0] pm_byte(input logic [15:0] word, input logic odd);
		pm_byte = odd ? word[15:8] : word[7:0];
	endfunction

	function automatic logic [7:0] put_bit(input logic [7:0] value, input logic [2:0] pos,
		input logic level);
		logic [7:0] tmp;
		tmp = value;
		tmp[pos] = level;
		put_bit = tmp;
	endfunction

	// ----------------------------------------------------------------
	// Shift unit
	// ----------------------------------------------------------------
	ctbs_shifter u_shifter (
		.op(cmd.op),
		.value(cmd.dst_val),
		.carry_in(st_q.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_C]),
		.res(shift_res)
	);

	assign accept = cmd_valid && st_q.ready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		st_d.rf_wr.en = 1'b0;
		st_d.z_wr.en = 1'b0;
		st_d.pm.rd_en = 1'b0;
		st_d.pm.wr_en = 1'b0;
		st_d.io_wr.en = 1'b0;
		st_d.stk.push = 1'b0;
		st_d.stk.pop = 1'b0;
		case (st_q.state)
			ST_IDLE: begin
				if (accept) begin
					st_d.pend_op = cmd.op;
					st_d.pend_dst = cmd.dst;
					st_d.pend_odd = cmd.z[0];
					case (cmd.op)
						OP_PROGRAM_MEMORY_READ_R0: begin
							st_d.pm.rd_en = 1'b1;
							st_d.pm.addr = cmd.z;
							st_d.pend_dst = `CTBS_R0_INDEX;
							st_d.ready = 1'b0;
							st_d.state = ST_STEP1;
						end
						OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_INC: begin
							st_d.pm.rd_en = 1'b1;
							st_d.pm.addr = cmd.z;
							st_d.ready = 1'b0;
							st_d.state = ST_STEP1;
							if (cmd.op == OP_PROGRAM_MEMORY_READ_INC) begin
								st_d.z_wr.en = 1'b1;
								st_d.z_wr.data = cmd.z + `CTBS_Z_STEP;
							end
						end
						OP_PROGRAM_MEMORY_WRITE: begin
							st_d.pm.wr_en = 1'b1;
							st_d.pm.addr = cmd.z;
							st_d.pm.wdata = cmd.word;
							st_d.done = 1'b1;
						end
						OP_IO_IN: begin
							st_d.rf_wr.en = 1'b1;
							st_d.rf_wr.idx = cmd.dst;
							st_d.rf_wr.data = io_rd_data;
							st_d.done = 1'b1;
						end
						OP_IO_OUT: begin
							st_d.io_wr.en = 1'b1;
							st_d.io_wr.addr = cmd.io_addr;
							st_d.io_wr.data = cmd.src_val;
							st_d.done = 1'b1;
						end
						OP_PUSH: begin
							st_d.stk.push = 1'b1;
							st_d.stk.wdata = cmd.src_val;
							st_d.ready = 1'b0;
							st_d.state = ST_STEP1;
						end
						OP_POP: begin
							st_d.stk.pop = 1'b1;
							st_d.ready = 1'b0;
							st_d.state = ST_STEP1;
						end
						OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
							st_d.io_wr.en = 1'b1;
							st_d.io_wr.addr = cmd.io_addr;
							st_d.io_wr.data = put_bit(io_rd_data, cmd.bit_sel, cmd.op == OP_IO_BIT_SET);
							st_d.ready = 1'b0;
							st_d.state = ST_STEP1;
						end
						OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
						OP_ROTATE_RIGHT_CARRY, OP_ARITHMETIC_RIGHT_SHIFT: begin
							st_d.rf_wr.en = 1'b1;
							st_d.rf_wr.idx = cmd.dst;
							st_d.rf_wr.data = shift_res.result;
							// Only Z, C, N, V move; S, H, T, I stay
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_C] = shift_res.c;
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_Z] = shift_res.z;
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_N] = shift_res.n;
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_V] = shift_res.v;
							st_d.done = 1'b1;
						end
						OP_NIBBLE_SWAP: begin
							st_d.rf_wr.en = 1'b1;
							st_d.rf_wr.idx = cmd.dst;
							st_d.rf_wr.data = {cmd.dst_val[3:0], cmd.dst_val[7:4]};
							st_d.done = 1'b1;
						end
						OP_FLAG_SET_GENERIC: begin
							st_d.status_flags_register[cmd.bit_sel] = 1'b1;
							st_d.done = 1'b1;
						end
						OP_FLAG_CLEAR_GENERIC: begin
							st_d.status_flags_register[cmd.bit_sel] = 1'b0;
							st_d.done = 1'b1;
						end
						OP_BIT_TO_TRANSFER_FLAG: begin
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_T] = cmd.src_val[cmd.bit_sel];
							st_d.done = 1'b1;
						end
						OP_BIT_FROM_TRANSFER_FLAG: begin
							st_d.rf_wr.en = 1'b1;
							st_d.rf_wr.idx = cmd.dst;
							st_d.rf_wr.data = put_bit(cmd.dst_val, cmd.bit_sel, st_q.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_T]);
							st_d.done = 1'b1;
						end
						OP_CARRY_FORCE_ONE: begin
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_C] = 1'b1;
							st_d.done = 1'b1;
						end
						OP_CARRY_FORCE_ZERO: begin
							st_d.status_flags_register[`CTBS_STATUS_FLAGS_REGISTER_C] = 1'b0;
							st_d.done = 1'b1;
						end
						default: begin
							st_d.done = 1'b1;
						end
					endcase
				end else if (status_flags_register_load_en) begin
					// Flag updates from the rest of the core, only between commands
					st_d.status_flags_register = status_flags_register_load_val;
				end
			end
			ST_STEP1: begin
				case (st_q.pend_op)
					OP_PROGRAM_MEMORY_READ_R0, OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_INC: begin
						st_d.state = ST_STEP2;
					end
					OP_POP: begin
						st_d.rf_wr.en = 1'b1;
						st_d.rf_wr.idx = st_q.pend_dst;
						st_d.rf_wr.data = stack_rd_data;
						st_d.ready = 1'b1;
						st_d.done = 1'b1;
						st_d.state = ST_IDLE;
					end
					default: begin
						// Push and I/O bit ops spend their second cycle here
						st_d.ready = 1'b1;
						st_d.done = 1'b1;
						st_d.state = ST_IDLE;
					end
				endcase
			end
			ST_STEP2: begin
				st_d.rf_wr.en = 1'b1;
				st_d.rf_wr.idx = st_q.pend_dst;
				st_d.rf_wr.data = pm_byte(pm_rd_data, st_q.pend_odd);
				st_d.ready = 1'b1;
				st_d.done = 1'b1;
				st_d.state = ST_IDLE;
			end
			default: begin
				st_d.ready = 1'b1;
				st_d.state = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.state <= ST_IDLE;
			st_q.pend_op <= OP_NOP;
			st_q.ready <= 1'b1;
			st_q.status_flags_register <= `CTBS_STATUS_FLAGS_REGISTER_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cmd_ready = st_q.ready;
	assign done = st_q.done;
	assign rf_wr = st_q.rf_wr;
	assign z_wr = st_q.z_wr;
	assign pm = st_q.pm;
	assign io_wr = st_q.io_wr;
	assign stk = st_q.stk;
	assign status_flags_register = st_q.status_flags_register;

endmodule

// ===== test/ctbs_core_assertions.sv
// Purpose: Port checker of the transfer, bit and shift group
// Assumes: Bound to every ctbs_core
// Notes: Latencies follow the hand-over timing
`timescale 1ns/1ns
module ctbs_core_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire ctbs_pkg::ctbs_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic [7:0] io_rd_data,
	input wire ctbs_pkg::ctbs_rf_wr_t rf_wr,
	input wire ctbs_pkg::ctbs_z_wr_t z_wr,
	input wire ctbs_pkg::ctbs_pm_t pm,
	input wire ctbs_pkg::ctbs_io_wr_t io_wr,
	input wire ctbs_pkg::ctbs_stk_t stk,
	input wire logic [7:0] status_flags_register,
	input wire logic done
);
	import ctbs_pkg::*;
	wire tk = cmd_valid && cmd_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	io_out_a: assert property (tk && cmd.op == OP_IO_OUT
		|=> io_wr.en && io_wr.data == $past(cmd.src_val) && done) else $error("bad out");
	io_in_a: assert property (tk && cmd.op == OP_IO_IN
		|=> rf_wr.en && rf_wr.data == $past(io_rd_data) && done) else $error("bad in");
	push_a: assert property (tk && cmd.op == OP_PUSH
		|=> stk.push && stk.wdata == $past(cmd.src_val) ##1 done) else $error("bad push");
	pop_a: assert property (tk && cmd.op == OP_POP
		|=> stk.pop ##1 rf_wr.en && done) else $error("bad pop");
	pm_inc_a: assert property (tk && cmd.op == OP_PROGRAM_MEMORY_READ_INC
		|=> pm.rd_en && z_wr.en && z_wr.data == $past(cmd.z) + 16'h0001 ##2 rf_wr.en && done) else $error("bad inc");
	pm_store_a: assert property (tk && cmd.op == OP_PROGRAM_MEMORY_WRITE
		|=> pm.wr_en && pm.wdata == $past(cmd.word) && pm.addr == $past(cmd.z)) else $error("bad store");
	carry_set_a: assert property (tk && cmd.op == OP_CARRY_FORCE_ONE
		|=> status_flags_register[0] && status_flags_register[7:1] == $past(status_flags_register[7:1])) else $error("bad carry");
	nib_swap_a: assert property (tk && cmd.op == OP_NIBBLE_SWAP
		|=> rf_wr.data == {$past(cmd.dst_val[3:0]), $past(cmd.dst_val[7:4])} && $stable(status_flags_register)) else $error("bad swap");
	cover property (tk && cmd.op == OP_POP);
	cover property (done && rf_wr.en);
	cover property (tk && cmd.op == OP_IO_BIT_SET);
endmodule

bind ctbs_core ctbs_core_chk u_ctbs_core_chk (.clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .io_rd_data, .rf_wr,
	.z_wr, .pm, .io_wr, .stk, .status_flags_register, .done);

// ===== test/ctbs_mem_model.sv
// Purpose: Program memory, I/O space and stack beside the core
// Assumes: Word index is addr[8:1]
// Notes: Program read data toggles when not valid; stack top shows combinationally
`timescale 1ns/1ns
module ctbs_mem_model (
	input wire logic clk,
	input wire ctbs_pkg::ctbs_pm_t pm,
	input wire ctbs_pkg::ctbs_stk_t stk,
	input wire ctbs_pkg::ctbs_io_wr_t io_wr,
	input wire logic [5:0] io_addr,
	output logic [15:0] pm_rd_data,
	output logic [7:0] stack_rd_data,
	output logic [7:0] io_rd_data
);
	import ctbs_pkg::*;
	logic [15:0] mem [256];
	logic [7:0] io [64];
	logic [7:0] st [64];
	logic [5:0] sp;
	initial pm_rd_data = 16'h0000;
	initial sp = 6'h00;
	// The core samples the top byte at the edge that ends its pop strobe
	assign stack_rd_data = st[sp - 6'h01];
	assign io_rd_data = io[io_addr];
	always @(posedge clk) begin
		if (io_wr.en) io[io_wr.addr] <= io_wr.data;
		if (pm.wr_en) mem[pm.addr[8:1]] <= pm.wdata;
		pm_rd_data <= pm.rd_en ? mem[pm.addr[8:1]] : ~pm_rd_data;
		if (stk.push) begin
			st[sp] <= stk.wdata;
			sp <= sp + 6'h01;
		end else if (stk.pop) begin
			sp <= sp - 6'h01;
		end
	end
endmodule

// ===== test/tb_cpu_transfer_bit_shift_ops.sv
// Purpose: Self-checking bench of ctbs_core
// Assumes: Notes queued in issue order
// Notes: Done pops one note
`timescale 1ns/1ns
module tb_cpu_transfer_bit_shift_ops;
	import ctbs_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	ctbs_cmd_t cmd = '0;
	ctbs_cmd_t c = '0;
	logic status_flags_register_load_en = 1'b0;
	logic [7:0] status_flags_register_load_val = 8'h00;
	logic cmd_ready, done;
	logic [7:0] io_rd_data, stack_rd_data, status_flags_register;
	logic [7:0] s = 8'h00;
	logic [15:0] pm_rd_data;
	ctbs_rf_wr_t rf_wr;
	ctbs_z_wr_t z_wr;
	ctbs_pm_t pm;
	ctbs_io_wr_t io_wr;
	ctbs_stk_t stk;
	logic [21:0] q [$];
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	ctbs_core u_ctbs_core (.clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .io_rd_data, .pm_rd_data,
		.stack_rd_data, .status_flags_register_load_en, .status_flags_register_load_val, .rf_wr, .z_wr, .pm, .io_wr, .stk, .status_flags_register, .done);
	ctbs_mem_model u_ctbs_mem_model (.clk, .pm, .stk, .io_wr, .io_addr(cmd.io_addr), .pm_rd_data,
		.stack_rd_data, .io_rd_data);
	task automatic chk(string nm, logic [21:0] got, logic [21:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Present c, note expected write-back and flags
	task automatic go(ctbs_op_t op, logic en, logic [4:0] ix, logic [7:0] d);
		c.op = op;
		q.push_back({en, en ? {ix, d} : 13'h0000, s});
		cmd <= c;
		cmd_valid <= 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
	endtask
	task automatic idle();
		cmd_valid <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [15:0] sh(ctbs_op_t op, logic [7:0] v, logic [7:0] f);
		logic [7:0] r;
		logic cy;
		case (op)
			OP_LOGICAL_LEFT_SHIFT: r = {v[6:0], 1'b0};
			OP_LOGICAL_RIGHT_SHIFT: r = {1'b0, v[7:1]};
			OP_ROTATE_LEFT_CARRY: r = {v[6:0], f[0]};
			OP_ROTATE_RIGHT_CARRY: r = {f[0], v[7:1]};
			default: r = {v[7], v[7:1]};
		endcase
		cy = (op == OP_LOGICAL_LEFT_SHIFT || op == OP_ROTATE_LEFT_CARRY) ? v[7] : v[0];
		f[3:0] = {r[7] ^ cy, r[7], r == 8'h00, cy};
		return {r, f};
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			test_done();
		end
		if (rstn && done === 1'b1) begin
			chk("result", {rf_wr.en, rf_wr.en ? {rf_wr.idx, rf_wr.data} : 13'h0000, status_flags_register}, q.pop_front());
		end
	end
	initial begin
		logic [7:0] v, r;
		ctbs_op_t o;
		int i;
		void'($urandom(52));
		c.dst = 5'h11;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 20; i++) begin
			if (i % 5 == 0) begin
				v = $urandom;
				status_flags_register_load_val <= v;
				status_flags_register_load_en <= 1'b1;
				idle();
				status_flags_register_load_en <= 1'b0;
				s = v;
			end
			o = ctbs_op_t'(5'h0b + 5'(i % 5));
			v = $urandom;
			c.dst_val = v;
			{r, s} = sh(o, v, s);
			go(o, 1'b1, c.dst, r);
		end
		v = c.dst_val;
		go(OP_NIBBLE_SWAP, 1'b1, c.dst, {v[3:0], v[7:4]});
		for (i = 0; i < 8; i++) begin
			c.bit_sel = 3'(i);
			s[i] = 1'b1;
			go(OP_FLAG_SET_GENERIC, 1'b0, 5'h00, 8'h00);
			s[i] = 1'b0;
			go(OP_FLAG_CLEAR_GENERIC, 1'b0, 5'h00, 8'h00);
			c.src_val = $urandom;
			s[6] = c.src_val[i];
			go(OP_BIT_TO_TRANSFER_FLAG, 1'b0, 5'h00, 8'h00);
		end
		v = c.dst_val;
		v[c.bit_sel] = s[6];
		go(OP_BIT_FROM_TRANSFER_FLAG, 1'b1, c.dst, v);
		s[0] = 1'b1;
		go(OP_CARRY_FORCE_ONE, 1'b0, 5'h00, 8'h00);
		s[0] = 1'b0;
		go(OP_CARRY_FORCE_ZERO, 1'b0, 5'h00, 8'h00);
		c.io_addr = 6'($urandom);
		c.src_val = $urandom;
		v = c.src_val;
		go(OP_IO_OUT, 1'b0, 5'h00, 8'h00);
		idle();
		go(OP_IO_IN, 1'b1, c.dst, v);
		c.bit_sel = 3'($urandom);
		v[c.bit_sel] = 1'b1;
		go(OP_IO_BIT_SET, 1'b0, 5'h00, 8'h00);
		go(OP_IO_IN, 1'b1, c.dst, v);
		v[c.bit_sel] = 1'b0;
		go(OP_IO_BIT_CLEAR, 1'b0, 5'h00, 8'h00);
		go(OP_IO_IN, 1'b1, c.dst, v);
		c.z = {7'h00, 8'($urandom), 1'b0};
		c.word = $urandom;
		go(OP_PROGRAM_MEMORY_WRITE, 1'b0, 5'h00, 8'h00);
		go(OP_PROGRAM_MEMORY_READ_R0, 1'b1, 5'h00, c.word[7:0]);
		c.z = c.z + 16'h0001;
		go(OP_PROGRAM_MEMORY_READ_INC, 1'b1, c.dst, c.word[15:8]);
		c.src_val = $urandom;
		v = c.src_val;
		go(OP_PUSH, 1'b0, 5'h00, 8'h00);
		c.src_val = $urandom;
		go(OP_PUSH, 1'b0, 5'h00, 8'h00);
		go(OP_POP, 1'b1, c.dst, c.src_val);
		go(OP_POP, 1'b1, c.dst, v);
		go(ctbs_op_t'(5'h1f), 1'b0, 5'h00, 8'h00);
		idle();
		repeat (4) @(posedge clk);
		chk("pending", 22'(q.size()), 22'h000000);
		test_done();
	end
endmodule
